// File: core/time_base_and_divider_output.sv
// periodic tick timer with interrupt and buzzer divider output
// assumes sys_clk is the high-frequency clock; low clock arrives on a pin
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
module time_base_and_divider_output
   import time_base_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // operating mode and low clock pin
   input  wire logic        lowSpeed,
   input  wire logic        lowFreqClock,
   // axi4-lite write address and data
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // axi4-lite write response
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi4-lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // interrupt and buzzer pin
   output logic             tickIrq,
   output logic             buzzerOutN
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [7:0]          ctrl_q, awAddr_q, arAddr_q;
   logic [3:0]          wStrb_q;
   logic [31:0]         wData_q, rdata_q, readWord;
   logic [2:0]          rate;
   logic [1:0]          status_q, mask_q, bresp_q, rresp_q, statusClr, status_d, buzzRate;
   logic [4:0]          tickIdx, buzzIdx;
   logic [HI_DIV_W-1:0] highDiv_q;
   logic [LO_DIV_W-1:0] lowDiv_q;
   logic                lowSync1_q, lowSync2_q, lowSync3_q, lowStable_q, lowRise;
   logic                src_q, irq_q, buzzerOutN_q, tapPrev_q;
   logic                awHeld_q, wHeld_q, arHeld_q, awHeld_d, wHeld_d, arHeld_d;
   logic                awready_q, wready_q, arready_q, bvalid_q, rvalid_q;
   logic                awTake, wTake, arTake, doWrite, doRead;
   logic                ctrlWrite, srcWrite, statusWrite, maskWrite, wrMapped, rdMapped;
   logic                tickEnable, buzzerEnable, useLow, rateLegal;
   logic                tickTap, buzzTap, tickEvent, misuseEvent;

   assign tickEnable   = ctrl_q[TICK_EN_BIT];
   assign buzzerEnable = ctrl_q[BUZZ_EN_BIT];
   assign rate         = ctrl_q[RATE_LSB +: 3];
   assign buzzRate     = ctrl_q[BUZZ_RATE_LSB +: 2];

   // ----------------------------------------
   // low clock pin synchroniser
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         lowSync1_q  <= 1'b0;
         lowSync2_q  <= 1'b0;
         lowSync3_q  <= 1'b0;
         lowStable_q <= 1'b0;
      end else begin
         lowSync1_q <= lowFreqClock;
         lowSync2_q <= lowSync1_q;
         lowSync3_q <= lowSync2_q;
         if (lowSync2_q == lowSync3_q) begin
            lowStable_q <= lowSync3_q;
         end
      end
   end

   assign lowRise = !lowStable_q && lowSync2_q && lowSync3_q;

   // ----------------------------------------
   // free-running divider chains
   // ----------------------------------------
   // never cleared by software, so the first tick may come early
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         highDiv_q <= '0;
         lowDiv_q  <= '0;
      end else begin
         highDiv_q <= highDiv_q + HI_DIV_W'(1);
         if (lowRise) begin
            lowDiv_q <= lowDiv_q + LO_DIV_W'(1);
         end
      end
   end

   // ----------------------------------------
   // tap selection
   // ----------------------------------------
   always_comb begin
      useLow    = src_q || lowSpeed;
      rateLegal = !lowSpeed || (rate <= LOW_SPEED_MAX);
      tickIdx   = useLow ? TICK_LO_BIT[rate] : TICK_HI_BIT[rate];
      buzzIdx   = useLow ? BUZZ_LO_BIT[buzzRate] : BUZZ_HI_BIT[buzzRate];
      tickTap   = useLow ? lowDiv_q[tickIdx[3:0]] : highDiv_q[tickIdx];
      buzzTap   = useLow ? lowDiv_q[buzzIdx[3:0]] : highDiv_q[buzzIdx];
   end

   // ----------------------------------------
   // tick generation
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tapPrev_q <= 1'b0;
      end else begin
         tapPrev_q <= tickTap;
      end
   end

   // illegal low-speed codes give no tick at all
   assign tickEvent = tickEnable && rateLegal && tapPrev_q && !tickTap;

   // ----------------------------------------
   // buzzer pin
   // ----------------------------------------
   // idle level is high so the active-low pin stays quiet
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         buzzerOutN_q <= 1'b1;
      end else begin
         buzzerOutN_q <= buzzerEnable ? !buzzTap : 1'b1;
      end
   end

   // ----------------------------------------
   // axi4-lite handshakes
   // ----------------------------------------
   assign awTake  = awvalid && awready_q;
   assign wTake   = wvalid && wready_q;
   assign arTake  = arvalid && arready_q;
   assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
   assign doRead  = arHeld_q && !rvalid_q;

   always_comb begin
      awHeld_d = doWrite ? 1'b0 : (awTake ? 1'b1 : awHeld_q);
      wHeld_d  = doWrite ? 1'b0 : (wTake ? 1'b1 : wHeld_q);
      arHeld_d = doRead ? 1'b0 : (arTake ? 1'b1 : arHeld_q);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         awHeld_q  <= 1'b0;
         wHeld_q   <= 1'b0;
         arHeld_q  <= 1'b0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         arready_q <= 1'b0;
      end else begin
         awHeld_q  <= awHeld_d;
         wHeld_q   <= wHeld_d;
         arHeld_q  <= arHeld_d;
         awready_q <= !awHeld_d;
         wready_q  <= !wHeld_d;
         arready_q <= !arHeld_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         awAddr_q <= 8'h00;
         wData_q  <= 32'h0000_0000;
         wStrb_q  <= 4'h0;
         arAddr_q <= 8'h00;
      end else begin
         if (awTake) begin
            awAddr_q <= awaddr;
         end
         if (wTake) begin
            wData_q <= wdata;
            wStrb_q <= wstrb;
         end
         if (arTake) begin
            arAddr_q <= araddr;
         end
      end
   end

   // ----------------------------------------
   // write decode and response
   // ----------------------------------------
   always_comb begin
      ctrlWrite   = doWrite && (awAddr_q[7:2] == CTRL_OFFSET[7:2]);
      srcWrite    = doWrite && (awAddr_q[7:2] == SRC_OFFSET[7:2]);
      statusWrite = doWrite && (awAddr_q[7:2] == STATUS_OFFSET[7:2]);
      maskWrite   = doWrite && (awAddr_q[7:2] == MASK_OFFSET[7:2]);
      wrMapped    = ctrlWrite || srcWrite || statusWrite || maskWrite;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (doWrite) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // control, source and mask registers
   // ----------------------------------------
   // rate and enable may arrive in the same write
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ctrl_q <= CTRL_RESET;
         src_q  <= SRC_RESET;
         mask_q <= MASK_RESET;
      end else begin
         if (ctrlWrite && wStrb_q[0]) begin
            ctrl_q <= wData_q[7:0] & CTRL_WRITABLE;
         end
         if (srcWrite && wStrb_q[0]) begin
            src_q <= wData_q[0];
         end
         if (maskWrite && wStrb_q[0]) begin
            mask_q <= wData_q[1:0];
         end
      end
   end

   // ----------------------------------------
   // status and interrupt
   // ----------------------------------------
   // flags a rate change made while the matching output runs
   assign misuseEvent = ctrlWrite && wStrb_q[0] &&
                        ((tickEnable && (wData_q[RATE_LSB +: 3] != rate)) ||
                         (buzzerEnable && (wData_q[BUZZ_RATE_LSB +: 2] != buzzRate)));

   always_comb begin
      statusClr = (statusWrite && wStrb_q[0]) ? wData_q[1:0] : 2'h0;
      status_d  = status_q & ~statusClr;
      // a new event wins over a clear in the same cycle
      status_d[ST_TICK]   = status_d[ST_TICK] | tickEvent;
      status_d[ST_MISUSE] = status_d[ST_MISUSE] | misuseEvent;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         status_q <= STATUS_RESET;
         irq_q    <= 1'b0;
      end else begin
         status_q <= status_d;
         irq_q    <= |(status_q & mask_q);
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   always_comb begin
      readWord = 32'h0000_0000;
      rdMapped = 1'b1;
      if (arAddr_q[7:2] == CTRL_OFFSET[7:2]) begin
         readWord[7:0] = ctrl_q;
      end else if (arAddr_q[7:2] == SRC_OFFSET[7:2]) begin
         readWord[0] = src_q;
      end else if (arAddr_q[7:2] == STATUS_OFFSET[7:2]) begin
         readWord[1:0] = status_q;
      end else if (arAddr_q[7:2] == MASK_OFFSET[7:2]) begin
         readWord[1:0] = mask_q;
      end else begin
         rdMapped = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OKAY;
      end else if (doRead) begin
         rvalid_q <= 1'b1;
         rdata_q  <= readWord;
         rresp_q  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign awready    = awready_q;
   assign wready     = wready_q;
   assign bvalid     = bvalid_q;
   assign bresp      = bresp_q;
   assign arready    = arready_q;
   assign rvalid     = rvalid_q;
   assign rdata      = rdata_q;
   assign rresp      = rresp_q;
   assign tickIrq    = irq_q;
   assign buzzerOutN = buzzerOutN_q;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_fall_enabled;
      tickEnable && rateLegal && tapPrev_q && !tickTap;
   endsequence
   sequence s_ctrl_write;
      ctrlWrite && wStrb_q[0];
   endsequence

   property p_tick_on_fall;
      s_fall_enabled |=> status_q[ST_TICK];
   endproperty
   a_tick_on_fall: assert property (p_tick_on_fall) else $error("tick edge not flagged");
   property p_tick_cause;
      !status_q[ST_TICK] ##1 status_q[ST_TICK] |-> $past(tickEnable) && !$past(tickTap) && $past(tapPrev_q);
   endproperty
   a_tick_cause: assert property (p_tick_cause) else $error("tick flag without enabled falling edge");
   property p_divider_free;
      $rose(tickEnable) |-> highDiv_q == $past(highDiv_q) + HI_DIV_W'(1);
   endproperty
   a_divider_free: assert property (p_divider_free) else $error("divider disturbed by enable");
   property p_hi_tap;
      !src_q && !lowSpeed && rate == 3'h2 |-> tickTap == highDiv_q[15];
   endproperty
   a_hi_tap: assert property (p_hi_tap) else $error("wrong high clock tick tap");
   property p_lo_tap;
      src_q && !lowSpeed && rate == 3'h7 |-> tickTap == lowDiv_q[0];
   endproperty
   a_lo_tap: assert property (p_lo_tap) else $error("wrong low clock tick tap");
   property p_low_speed_codes;
      lowSpeed && rate > 3'h1 && !status_q[ST_TICK] |=> !status_q[ST_TICK];
   endproperty
   a_low_speed_codes: assert property (p_low_speed_codes) else $error("tick from illegal low-speed code");
   property p_rate_and_enable;
      s_ctrl_write ##1 1'b1 |-> ctrl_q == ($past(wData_q[7:0]) & CTRL_WRITABLE) && ctrl_q[4] == 1'b0;
   endproperty
   a_rate_and_enable: assert property (p_rate_and_enable) else $error("control write not taken whole");
   property p_buzz_wave;
      buzzerEnable |=> buzzerOutN_q == !$past(buzzTap);
   endproperty
   a_buzz_wave: assert property (p_buzz_wave) else $error("buzzer pin not following tap");
   property p_buzz_off;
      !buzzerEnable [*2] |-> buzzerOutN_q;
   endproperty
   a_buzz_off: assert property (p_buzz_off) else $error("buzzer pin active while disabled");
   property p_buzz_tap;
      (src_q || lowSpeed) && buzzRate == 2'h3 |-> buzzTap == lowDiv_q[1];
   endproperty
   a_buzz_tap: assert property (p_buzz_tap) else $error("wrong buzzer tap");
   property p_ctrl_layout;
      s_ctrl_write ##1 1'b1 |-> tickEnable == $past(wData_q[3]) && buzzerEnable == $past(wData_q[7]);
   endproperty
   a_ctrl_layout: assert property (p_ctrl_layout) else $error("control bit layout wrong");

endmodule

// File: core/time_base_pkg.sv
// constants of the periodic tick timer and buzzer divider block
// assumes one 20 MHz core clock and an AXI4-Lite master with 32-bit data
//
// Behaviour
// - tick on each selected-tap falling edge while enabled
// - enabling never clears the shared divider chain
// - high clock tick taps 2^23 down to 2^9
// - low clock tick taps 2^15 down to 2
// - low-speed modes allow only codes 000, 001
// - one write may set rate and enable
// - buzzer pin drives half-duty square wave, active low
// - buzzer enable, rate share the control register
// - buzzer taps 2^13..2^10 high, 2^5..2^2 low
package time_base_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFFSET   = 8'h00;
   localparam logic [7:0] SRC_OFFSET    = 8'h04;
   localparam logic [7:0] STATUS_OFFSET = 8'h08;
   localparam logic [7:0] MASK_OFFSET   = 8'h0C;

   // ----------------------------------------
   // fields and reset values
   // ----------------------------------------
   localparam int         RATE_LSB      = 0;
   localparam int         TICK_EN_BIT   = 3;
   localparam int         BUZZ_RATE_LSB = 5;
   localparam int         BUZZ_EN_BIT   = 7;
   localparam logic [7:0] CTRL_RESET    = 8'h00;
   localparam logic [7:0] CTRL_WRITABLE = 8'hEF;
   localparam logic       SRC_RESET     = 1'h0;
   localparam logic [1:0] STATUS_RESET  = 2'h0;
   localparam logic [1:0] MASK_RESET    = 2'h0;
   localparam int         ST_TICK       = 0;
   localparam int         ST_MISUSE     = 1;
   localparam logic [2:0] LOW_SPEED_MAX = 3'h1;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   // ----------------------------------------
   // divider chains and tap bit tables, indexed by rate code
   // ----------------------------------------
   localparam int HI_DIV_W = 23;
   localparam int LO_DIV_W = 15;
   localparam logic [7:0][4:0] TICK_HI_BIT = {5'h08, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0F, 5'h14, 5'h16};
   localparam logic [7:0][4:0] TICK_LO_BIT = {5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h0C, 5'h0E};
   localparam logic [3:0][4:0] BUZZ_HI_BIT = {5'h09, 5'h0A, 5'h0B, 5'h0C};
   localparam logic [3:0][4:0] BUZZ_LO_BIT = {5'h01, 5'h02, 5'h03, 5'h04};

endpackage

// File: tb/low_clock_source.sv
// partner model: free-running low-frequency crystal on the low clock pin
// assumes the block samples the pin through its own synchroniser
`timescale 1ns/1ns
module low_clock_source #(
   parameter int HALF_NS   = 200,
   parameter int OFFSET_NS = 13
) (
   // low clock pin
   output logic lowFreqClock
);
   // a crystal never stops, so there is no idle level to model
   // odd offset keeps its edges away from the core clock edges
   initial begin
      lowFreqClock = 1'b0;
      #OFFSET_NS;
      forever begin
         #HALF_NS lowFreqClock = ~lowFreqClock;
      end
   end
endmodule

// File: tb/test_time_base_and_divider_output.sv
// self-checking bench for the tick timer and buzzer divider block
// assumes a 20 MHz core clock and a low clock of eight core cycles
`timescale 1ns/1ns
module test_time_base_and_divider_output
   import time_base_pkg::*;
;
   // ----------------------------------------
   // stimulus signals
   // ----------------------------------------
   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        lowSpeed = 1'b0;
   wire         lowFreqClock;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, tickIrq, buzzerOutN;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   int          failures = 0;
   int          tests_run = 0;
   int          cyc = 0;
   logic [1:0]  bq[$];
   logic [33:0] rq[$];
   // tap exponents per rate code; low clock period in core cycles
   localparam int LOW_PER = 8;
   localparam int HI_TICK[8] = '{23, 21, 16, 14, 13, 12, 11, 9};
   localparam int LO_TICK[8] = '{15, 13, 8, 6, 5, 4, 3, 1};
   localparam int HI_BUZZ[4] = '{13, 12, 11, 10};
   localparam int LO_BUZZ[4] = '{5, 4, 3, 2};

   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) cyc <= cyc + 1;

   time_base_and_divider_output time_base_and_divider_output_i (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .lowSpeed(lowSpeed), .lowFreqClock(lowFreqClock),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .tickIrq(tickIrq), .buzzerOutN(buzzerOutN)
   );
   low_clock_source low_clock_source_i (.lowFreqClock(lowFreqClock));

   // ----------------------------------------
   // checking and bus tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // monitor: oldest noted answer against what the bus returns
   always @(posedge sys_clk) begin
      if (rvalid === 1'b1 && rready) chk("read", rq.size() > 0 ? rq.pop_front() : 'x, {rresp, rdata});
      if (bvalid === 1'b1 && bready) chk("bresp", bq.size() > 0 ? 34'(bq.pop_front()) : 'x, 34'(bresp));
   end

   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bq.push_back(er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      bready <= 1'b0;
      // one idle edge so the next request never lands in this time step
      @(posedge sys_clk);
   endtask

   task automatic axr(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
      rq.push_back({er, ed});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      rready <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic waitRise(output int t);
      while (tickIrq === 1'b1) @(posedge sys_clk);
      while (tickIrq !== 1'b1) @(posedge sys_clk);
      t = cyc;
   endtask

   task automatic runLen(input logic lvl, output int n);
      n = 0;
      while (buzzerOutN === lvl) begin
         @(posedge sys_clk);
         n++;
      end
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic tickCase(input logic src, input logic [2:0] code);
      int t0, t1, per;
      per = src ? (1 << LO_TICK[code]) * LOW_PER : 1 << HI_TICK[code];
      axw(SRC_OFFSET, {31'h0, src}, RESP_OKAY);
      axw(STATUS_OFFSET, 32'h3, RESP_OKAY);
      axw(CTRL_OFFSET, {28'h0, 1'b1, code}, RESP_OKAY);
      waitRise(t0);
      axw(STATUS_OFFSET, 32'h1, RESP_OKAY);
      waitRise(t1);
      chk("tick period", 34'(per), 34'(t1 - t0));
      axw(CTRL_OFFSET, {29'h0, code}, RESP_OKAY);
   endtask

   task automatic buzzCase(input logic ls, input logic src, input logic [1:0] code);
      int hi, lo, half;
      half = (ls || src) ? (1 << LO_BUZZ[code]) * LOW_PER / 2 : (1 << HI_BUZZ[code]) / 2;
      lowSpeed <= ls;
      axw(SRC_OFFSET, {31'h0, src}, RESP_OKAY);
      axw(CTRL_OFFSET, {24'h0, 1'b1, code, 5'h0}, RESP_OKAY);
      runLen(1'b1, hi);
      runLen(1'b0, lo);
      runLen(1'b1, hi);
      runLen(1'b0, lo);
      chk("buzzer high", 34'(half), 34'(hi));
      chk("buzzer low", 34'(half), 34'(lo));
      axw(CTRL_OFFSET, {24'h0, 1'b0, code, 5'h0}, RESP_OKAY);
      repeat (3) @(posedge sys_clk);
      chk("buzzer idle", 34'h1, {33'h0, buzzerOutN});
   endtask

   task results;
      if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // long enough for every case, with margin, under the cycle budget
   initial begin
      #(100000 * 50);
      failures++;
      results();
   end

   initial begin
      logic [31:0] r;
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      void'($urandom(66));
      for (int i = 0; i < 4; i++) axr(8'(4 * i), RESP_OKAY, 32'h0);
      axr(8'h10, RESP_SLVERR, 32'h0);
      axw(8'h10, 32'hFF, RESP_SLVERR);
      // a write without its low byte lane changes nothing
      wstrb <= 4'h0;
      axw(CTRL_OFFSET, 32'hFF, RESP_OKAY);
      wstrb <= 4'hF;
      axr(CTRL_OFFSET, RESP_OKAY, 32'h0);
      axw(CTRL_OFFSET, 32'hFF, RESP_OKAY);
      axr(CTRL_OFFSET, RESP_OKAY, {24'h0, CTRL_WRITABLE});
      axw(CTRL_OFFSET, 32'h67, RESP_OKAY);
      // rate change while running is flagged in status bit 1
      axw(STATUS_OFFSET, 32'h3, RESP_OKAY);
      axw(CTRL_OFFSET, 32'h0A, RESP_OKAY);
      axw(CTRL_OFFSET, 32'h0B, RESP_OKAY);
      axr(STATUS_OFFSET, RESP_OKAY, 32'h2);
      axw(CTRL_OFFSET, 32'h03, RESP_OKAY);
      repeat (4) begin
         r = $urandom();
         axw(MASK_OFFSET, r, RESP_OKAY);
         axr(MASK_OFFSET, RESP_OKAY, r & 32'h3);
      end
      // masked tick: status sets, pin stays quiet until unmasked
      axw(MASK_OFFSET, 32'h0, RESP_OKAY);
      axw(STATUS_OFFSET, 32'h3, RESP_OKAY);
      axw(CTRL_OFFSET, 32'h0F, RESP_OKAY);
      repeat (600) @(posedge sys_clk);
      chk("irq masked", 34'h0, {33'h0, tickIrq});
      axw(CTRL_OFFSET, 32'h07, RESP_OKAY);
      axr(STATUS_OFFSET, RESP_OKAY, 32'h1);
      axw(MASK_OFFSET, 32'h1, RESP_OKAY);
      chk("irq unmasked", 34'h1, {33'h0, tickIrq});
      axw(STATUS_OFFSET, 32'h1, RESP_OKAY);
      chk("irq cleared", 34'h0, {33'h0, tickIrq});
      // low-speed mode with a fast code must never tick
      lowSpeed <= 1'b1;
      axw(CTRL_OFFSET, 32'h0F, RESP_OKAY);
      repeat (600) @(posedge sys_clk);
      axr(STATUS_OFFSET, RESP_OKAY, 32'h0);
      axw(CTRL_OFFSET, 32'h07, RESP_OKAY);
      lowSpeed <= 1'b0;
      tickCase(1'b0, 3'h7);
      tickCase(1'b0, 3'h6);
      tickCase(1'b0, 3'h5);
      tickCase(1'b1, 3'h4);
      tickCase(1'b1, 3'h7);
      buzzCase(1'b0, 1'b0, 2'h0);
      buzzCase(1'b0, 1'b0, 2'h3);
      buzzCase(1'b0, 1'b1, 2'h3);
      buzzCase(1'b1, 1'b0, 2'h0);
      results();
   end
endmodule
